/* src/hpp_pkg.sv */
// constants and types for the host-side controller of a 16-bit parallel
// processor port; assumes one 100 MHz clock and a synchronous reset.
//
// Contract
// - Direction-line style: direction pin low writes, high reads.
// - In strobe style a low write strobe writes, taken while it is low.
// - In strobe style a low read strobe has the device drive data.
// - In direction-line style the output-enable pin stays tied low; the host holds it high through reset until the style is taken.
package hpp_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    // access timing of the far device is not given; safe slow defaults
    localparam int T_SETUP_NS = 20;
    localparam int T_STROBE_NS = 60;
    localparam int T_HOLD_NS = 20;
    localparam logic [CNT_W-1:0] SETUP_CYC =
        CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] STROBE_CYC =
        CNT_W'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HOLD_CYC =
        CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic {
        HPP_STYLE_DIR = 1'b0,
        HPP_STYLE_STROBE = 1'b1
    } hpp_style_t;

    typedef enum logic [1:0] {
        HPP_IDLE = 2'h0,
        HPP_SETUP = 2'h1,
        HPP_STROBE = 2'h3,
        HPP_HOLD = 2'h2
    } hpp_state_t;
endpackage

/* src/hpp_tmr_if.sv */
// phase timer hookup between the access sequencer and its down-counter;
// both ends sit on the same clock.
`timescale 1ns/10ps
interface hpp_tmr_if #(
    parameter int CNT_W = 8
);
    logic load;
    logic [CNT_W-1:0] count;
    logic expire;

    modport ctl (output load, output count, input expire);
    modport tmr (input load, input count, output expire);
endinterface

/* src/hpp_phase_timer.sv */
// down-counter timing each phase of a bus access in whole clock cycles;
// assumes load is pulsed on the cycle a phase begins.
`timescale 1ns/10ps
module hpp_phase_timer #(
    parameter int CNT_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    hpp_tmr_if.tmr tmr
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } hpp_tmr_st_t;

    hpp_tmr_st_t r_reg;
    hpp_tmr_st_t r_next;

    if (CNT_W < 2) begin : g_chk
        $error("hpp_phase_timer: CNT_W must be at least 2");
    end

    // a phase of n cycles expires on its n-th cycle; zero is read as one
    always_comb begin
        r_next = r_reg;
        if (tmr.load) begin
            r_next.cnt = (tmr.count == '0) ? '0 : tmr.count - 1'b1;
        end else if (r_reg.cnt != '0) begin
            r_next.cnt = r_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tmr.expire = (r_reg.cnt == '0);
endmodule

/* src/hpp_host.sv */
// host controller that runs single read and write accesses on a 16-bit
// parallel processor port; the far device and its pull-up on the
// interrupt line sit outside, and all pins are synchronous to clk_i.
`timescale 1ns/10ps
module hpp_host #(
    parameter int ADDR_W = hpp_pkg::ADDR_W,
    parameter int DATA_W = hpp_pkg::DATA_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic style_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic ready_o,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic irq_o,
    output logic cs_n_o,
    output logic dir_wr_n_o,
    output logic oe_rd_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic irq_n_i
);
    import hpp_pkg::*;

    typedef struct packed {
        hpp_state_t st;
        logic cfg_ok;
        hpp_style_t style;
        logic we;
        logic cs_n;
        logic dir_wr_n;
        logic oe_rd_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic doe;
        logic [DATA_W-1:0] rdata;
        logic done;
        logic irq;
    } hpp_host_st_t;

    hpp_host_st_t r_reg;
    hpp_host_st_t r_next;
    logic phase_act;
    logic phase_busy;
    // edges from the taking edge to the one that shows done_o
    localparam int DONE_LAT = SETUP_CYC + STROBE_CYC + HOLD_CYC + 1;

    hpp_tmr_if #(.CNT_W(CNT_W)) tmr_if ();

    hpp_phase_timer #(.CNT_W(CNT_W)) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tmr(tmr_if.tmr)
    );

    if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 1 || DATA_W > 64) begin : g_chk
        $error("hpp_host: ADDR_W must be 1..32 and DATA_W 1..64");
    end

    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        tmr_if.load = 1'b0;
        tmr_if.count = '0;
        phase_act = 1'b0;
        phase_busy = 1'b0;
        // style is taken once after reset and then frozen
        if (!r_reg.cfg_ok) begin
            r_next.cfg_ok = 1'b1;
            r_next.style = hpp_style_t'(style_i);
        end
        case (r_reg.st)
            HPP_IDLE: begin
                if (r_reg.cfg_ok && req_i) begin
                    r_next.st = HPP_SETUP;
                    r_next.we = we_i;
                    r_next.addr = addr_i;
                    r_next.wdata = wdata_i;
                    tmr_if.load = 1'b1;
                    tmr_if.count = SETUP_CYC;
                end
            end
            HPP_SETUP: begin
                if (tmr_if.expire) begin
                    r_next.st = HPP_STROBE;
                    tmr_if.load = 1'b1;
                    tmr_if.count = STROBE_CYC;
                end
            end
            HPP_STROBE: begin
                if (tmr_if.expire) begin
                    r_next.st = HPP_HOLD;
                    tmr_if.load = 1'b1;
                    tmr_if.count = HOLD_CYC;
                    // sampled at the strobe's last cycle, data long settled
                    if (!r_reg.we) begin
                        r_next.rdata = data_i;
                    end
                end
            end
            HPP_HOLD: begin
                if (tmr_if.expire) begin
                    r_next.st = HPP_IDLE;
                    r_next.done = 1'b1;
                end
            end
            default: begin
                r_next.st = HPP_IDLE;
            end
        endcase
        r_next.irq = ~irq_n_i;
        // pins are derived from the next state so they leave flip-flops
        phase_act = (r_next.st == HPP_STROBE);
        phase_busy = (r_next.st != HPP_IDLE);
        // select only in the strobe phase; address settles before it
        r_next.cs_n = ~phase_act;
        if (r_next.style == HPP_STYLE_DIR) begin
            // idle level is read, so a stray select never writes
            r_next.dir_wr_n = ~(phase_busy & r_next.we);
            r_next.oe_rd_n = 1'b0;
        end else begin
            r_next.dir_wr_n = ~(phase_act & r_next.we);
            r_next.oe_rd_n = ~(phase_act & ~r_next.we);
        end
        // the hold phase keeps our write data driven after the strobe ends
        r_next.doe = phase_busy & r_next.we;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '{st: HPP_IDLE, cfg_ok: 1'b0, style: HPP_STYLE_DIR,
                       we: 1'b0, cs_n: 1'b1, dir_wr_n: 1'b1,
                       oe_rd_n: 1'b1, addr: '0, wdata: '0, doe: 1'b0,
                       rdata: '0, done: 1'b0, irq: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign ready_o = (r_reg.st == HPP_IDLE) & r_reg.cfg_ok;
    assign done_o = r_reg.done;
    assign rdata_o = r_reg.rdata;
    assign irq_o = r_reg.irq;
    assign cs_n_o = r_reg.cs_n;
    assign dir_wr_n_o = r_reg.dir_wr_n;
    assign oe_rd_n_o = r_reg.oe_rd_n;
    assign addr_o = r_reg.addr;
    assign data_o = r_reg.wdata;
    assign data_oe_o = r_reg.doe;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DIR_LEVEL: assert property (
        (!cs_n_o && r_reg.style == HPP_STYLE_DIR)
            |-> (dir_wr_n_o == !r_reg.we))
        else $error("direction pin disagrees with access kind");

    AST_WR_STROBE: assert property (
        (r_reg.style == HPP_STYLE_STROBE && !dir_wr_n_o)
            |-> (!cs_n_o && data_oe_o && r_reg.we))
        else $error("write strobe low without select or driven data");

    AST_RD_STROBE: assert property (
        (r_reg.style == HPP_STYLE_STROBE && !oe_rd_n_o)
            |-> (!cs_n_o && !data_oe_o))
        else $error("read strobe low while host drives or unselected");

    AST_OE_TIED: assert property (
        (r_reg.style == HPP_STYLE_DIR && r_reg.cfg_ok) |-> !oe_rd_n_o)
        else $error("output enable not held low in direction style");

    AST_SEL_WIDTH: assert property (
        $fell(cs_n_o) |-> !cs_n_o [*6] ##1 cs_n_o)
        else $error("select low phase is not six cycles");

    AST_SETUP_FIRST: assert property (
        $rose(data_oe_o) |-> cs_n_o [*2] ##1 !cs_n_o)
        else $error("write data not set up two cycles before select");

    AST_READ_DONE: assert property (
        ($rose(cs_n_o) && !r_reg.we) |-> ##1 (!done_o) ##1 done_o)
        else $error("read completion not two cycles after strobe");

    // a taken request finishes on a fixed edge; no wait states exist
    AST_DONE_LAT: assert property (
        (ready_o && req_i) |-> ##DONE_LAT done_o)
        else $error("access did not finish on its fixed cycle");

    AST_SEL_GAP: assert property (
        $rose(cs_n_o) |-> cs_n_o [*4])
        else $error("select released for fewer than four cycles");

    AST_ADDR_HELD: assert property (
        !cs_n_o |-> ($stable(addr_o) && $stable(data_o)))
        else $error("address or write data moved while selected");

    AST_DIR_HELD: assert property (
        (!cs_n_o && r_reg.style == HPP_STYLE_DIR) |-> $stable(dir_wr_n_o))
        else $error("direction pin moved while selected");

    AST_IDLE_QUIET: assert property (
        (r_reg.st == HPP_IDLE) |-> (cs_n_o && !data_oe_o))
        else $error("select or data drive active while idle");

    AST_IRQ_FOLLOW: assert property (
        r_reg.cfg_ok |-> (irq_o == !$past(irq_n_i)))
        else $error("interrupt flag does not follow the line");

    COV_WRITE_DIR: cover property (
        !cs_n_o && r_reg.we && r_reg.style == HPP_STYLE_DIR);
    COV_READ_STROBE: cover property (
        !oe_rd_n_o && r_reg.style == HPP_STYLE_STROBE);
    COV_BACK_TO_BACK: cover property (done_o ##1 !ready_o);
    COV_IRQ: cover property ($rose(irq_o));
endmodule

/* test/hpp_dev_model.sv */
// behavioural model of the far device on the parallel processor port;
// assumes its pins change only just after rising edges of clk_i.
`timescale 1ns/10ps
module hpp_dev_model (
    input wire logic clk_i,
    input wire logic style_i,
    input wire logic cs_n_i,
    input wire logic dir_wr_n_i,
    input wire logic oe_rd_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [15:0] data_i,
    input wire logic pend_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    output logic irq_n_o
);
    logic [15:0] mem [0:4095];
    logic rd_sel;
    logic wr_sel;
    // nothing is decoded while chip select is high
    assign rd_sel = !cs_n_i && (style_i ? !oe_rd_n_i : dir_wr_n_i);
    assign wr_sel = !cs_n_i && !dir_wr_n_i;
    assign data_oe_o = rd_sel;
    assign data_o = mem[addr_i];
    // pulled low when pending and driven high otherwise, not open drain
    assign irq_n_o = pend_i ? 1'b0 : 1'b1;
    always @(posedge clk_i) begin
        if (wr_sel) begin
            mem[addr_i] <= data_i;
        end
    end
endmodule

/* test/hpp_host_test.sv */
// self-checking bench for the host port controller against a device model;
// all stimulus lands by non-blocking assignment at rising clock edges.
`timescale 1ns/10ps
module hpp_host_test;
    logic clk_i = 0, rst_i = 1, style_i = 0, req_i = 0, we_i = 0, pend = 0;
    logic [11:0] addr_i = 0;
    logic [15:0] wdata_i = 0, data_i, dev_d, bus_last = 0;
    logic ready_o, done_o, irq_o, cs_n_o, dir_wr_n_o, oe_rd_n_o, data_oe_o;
    logic dev_oe, irq_n;
    logic [11:0] addr_o;
    logic [15:0] rdata_o, data_o;
    logic cur_style = 0;
    int fail_count = 0, compares = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    // an unowned bus shows the inverse of its last level, not a held value
    assign data_i = data_oe_o ? data_o : dev_oe ? dev_d : ~bus_last;
    always @(posedge clk_i) bus_last <= data_i;
    hpp_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .style_i(style_i),
        .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .irq_o(irq_o),
        .cs_n_o(cs_n_o), .dir_wr_n_o(dir_wr_n_o), .oe_rd_n_o(oe_rd_n_o),
        .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o),
        .data_i(data_i), .irq_n_i(irq_n));
    hpp_dev_model i_dev (.clk_i(clk_i), .style_i(cur_style), .cs_n_i(cs_n_o),
        .dir_wr_n_i(dir_wr_n_o), .oe_rd_n_i(oe_rd_n_o), .addr_i(addr_o),
        .data_i(data_i), .pend_i(pend), .data_o(dev_d), .data_oe_o(dev_oe),
        .irq_n_o(irq_n));
    task automatic check(input string what, input logic [15:0] exp, got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset(input logic st);
        @(posedge clk_i);
        rst_i <= 1'b1;
        style_i <= st;
        cur_style <= st;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic access(input logic we, input logic [11:0] a,
            input logic [15:0] wd, output logic [15:0] rd);
        int n = 0;
        int lo = 0;
        int lat = int'(hpp_pkg::SETUP_CYC) + int'(hpp_pkg::STROBE_CYC)
            + int'(hpp_pkg::HOLD_CYC) + 1;
        do begin
            @(negedge clk_i);
            n++;
        end while (ready_o !== 1'b1 && n < 50);
        @(posedge clk_i);
        req_i <= 1'b1;
        we_i <= we;
        addr_i <= a;
        wdata_i <= wd;
        @(posedge clk_i);
        req_i <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
            if (done_o !== 1'b1) check("ready_o", 0, ready_o);
            if (cur_style == 1'b0) check("oe_rd_n_o", 0, oe_rd_n_o);
            if (!we) check("data_oe_o", 0, data_oe_o);
            if (cs_n_o === 1'b0) begin
                lo++;
                check("addr_o", 16'(a), 16'(addr_o));
                check("dir_wr_n_o", 16'(!we), 16'(dir_wr_n_o));
                if (we) check("data_o", wd, data_o);
                if (we) check("data_oe_o", 1, data_oe_o);
                if (cur_style && !we)
                    check("oe_rd_n_o", 0, oe_rd_n_o);
            end
        end while (done_o !== 1'b1 && n < 50);
        check("done_o", 1, done_o);
        check("done cycle", 16'(lat), 16'(n));
        check("ready_o", 1, ready_o);
        check("select cycles", 16'(hpp_pkg::STROBE_CYC), 16'(lo));
        check("cs_n_o", 1, cs_n_o);
        rd = rdata_o;
    endtask
    task automatic test_rw(input logic st);
        logic [15:0] rd;
        logic [11:0] a [3] = '{12'h000, 12'h5a5, 12'hfff};
        do_reset(st);
        for (int i = 0; i < 3; i++) access(1'b1, a[i], {a[i], 3'h0, st}, rd);
        for (int i = 0; i < 3; i++) begin
            access(1'b0, a[i], 16'h0000, rd);
            check("rdata_o", {a[i], 3'h0, st}, rd);
        end
        $display("test_rw style %0d done", st);
    endtask
    task automatic test_style_hold;
        logic [15:0] rd;
        do_reset(1'b0);
        @(posedge clk_i);
        @(posedge clk_i);
        style_i <= 1'b1;
        access(1'b1, 12'h123, 16'hbeef, rd);
        access(1'b0, 12'h123, 16'h0000, rd);
        check("rdata_o", 16'hbeef, rd);
        $display("test_style_hold done");
    endtask
    task automatic test_irq;
        // the flag trails the line by exactly one edge
        @(posedge clk_i);
        pend <= 1'b1;
        @(negedge clk_i);
        check("irq_o", 0, irq_o);
        @(negedge clk_i);
        check("irq_o", 1, irq_o);
        @(posedge clk_i);
        pend <= 1'b0;
        @(negedge clk_i);
        check("irq_o", 1, irq_o);
        @(negedge clk_i);
        check("irq_o", 0, irq_o);
        $display("test_irq done");
    endtask
    task automatic summarize;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (data_oe_o === 1'b1 && dev_oe === 1'b1)
            check("contention", 0, 1);
        if (cyc == 5000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        test_rw(1'b0);
        test_rw(1'b1);
        test_style_hold();
        test_irq();
        summarize();
    end
endmodule
